/* File: verilog/oesc_top.sv */
// main and high speed oscillator enable and settle control
// assumes triggers are one-cycle write pulses from a register front end
`timescale 1ns/10ps
`include "oesc_defs.svh"
module oesc_top #(
	parameter int LS_DIV = `OESC_LS_DIV,
	parameter int HS_DIV = `OESC_HS_DIV
) (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic POWER_UP_RESET_I,
	input wire logic MAIN_OSC_START_TRIGGER_I,
	input wire logic MAIN_OSC_STOP_TRIGGER_I,
	input wire logic MAIN_OSC_STOP_MASK_I,
	input wire logic [3:0] MAIN_OSC_SETTLE_COUNT_I,
	input wire logic MAIN_OSC_FAST_SETTLE_I,
	input wire logic HS_OSC_START_TRIGGER_I,
	input wire logic HS_OSC_STOP_TRIGGER_I,
	input wire logic HS_OSC_STOP_MASK_I,
	input wire logic STANDBY_STOP_REQUEST_I,
	input wire logic WAKE_OSC_START_I,
	output logic MAIN_OSC_ENABLED_FLAG_O,
	output logic MAIN_OSC_STABLE_FLAG_O,
	output logic MAIN_OSC_ACTIVE_FLAG_O,
	output logic MAIN_OSC_GATE_O,
	output logic MAIN_OSC_MAX_GAIN_O,
	output logic MAIN_CLOCK_MONITOR_EN_O,
	output logic HS_OSC_ENABLED_FLAG_O,
	output logic HS_OSC_STABLE_FLAG_O,
	output logic HS_OSC_ACTIVE_FLAG_O,
	output logic HS_OSC_GATE_O,
	output logic HS_CLOCK_MONITOR_EN_O,
	output logic LS_OSC_RUN_O,
	output logic MONITOR_SAMPLE_TICK_O,
	output logic [3:0] TRIGGER_READBACK_O
);
	initial begin
		if (LS_DIV < 2 || HS_DIV < 2) $error("oesc_top: divider too small");
		if (LS_DIV > 65536 || HS_DIV > 65536) begin
			$error("oesc_top: divider too large");
		end
	end
	// ************************************************
	// settle clock enables
	// ************************************************
	logic [15:0] ls_cnt_q;
	logic [15:0] hs_cnt_q;
	logic ls_tick;
	logic hs_tick;
	logic settle_tick;
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ls_cnt_q <= '0;
		end else if (ls_tick) begin
			ls_cnt_q <= '0;
		end else begin
			ls_cnt_q <= ls_cnt_q + 16'h0001;
		end
	end
	assign ls_tick = (ls_cnt_q == 16'(LS_DIV - 1)); // R13
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			hs_cnt_q <= '0;
		end else if (hs_tick) begin
			hs_cnt_q <= '0;
		end else begin
			hs_cnt_q <= hs_cnt_q + 16'h0001;
		end
	end
	assign hs_tick = (hs_cnt_q == 16'(HS_DIV - 1));
	oesc_pkg::oesc_status_t main_st;
	oesc_pkg::oesc_status_t hs_st;
	assign settle_tick = hs_st.enabled ? hs_tick : ls_tick; // R7
	// ************************************************
	// main oscillator
	// ************************************************
	oesc_pkg::oesc_ctrl_t main_ctrl;
	logic [`OESC_CNT_W-1:0] main_target;
	logic main_settling;
	logic main_restart;
	logic main_wake;
	logic stop_req_q;
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			stop_req_q <= 1'b0;
		end else begin
			stop_req_q <= STANDBY_STOP_REQUEST_I;
		end
	end
	// wake start acts at the falling edge of the standby request
	assign main_wake = WAKE_OSC_START_I & stop_req_q
		& ~STANDBY_STOP_REQUEST_I & ~main_st.enabled; // R10 R11
	assign main_ctrl.start = MAIN_OSC_START_TRIGGER_I & ~main_st.active; // R2
	assign main_ctrl.stop = MAIN_OSC_STOP_TRIGGER_I & main_st.active; // R2
	assign main_ctrl.stop_mask = MAIN_OSC_STOP_MASK_I;
	assign main_target = `OESC_CNT_W'(1) << (MAIN_OSC_SETTLE_COUNT_I
		+ 5'(`OESC_SETTLE_MIN_EXP)); // R5
	oesc_osc_ctl #(
		.CNT_W(`OESC_CNT_W),
		.RESET_ON(1'b0)
	) u_main (
		.clk_i(CORE_CLK_I),
		.rst_i(POWER_UP_RESET_I), // R19
		.ctrl_i(main_ctrl),
		.stop_req_i(STANDBY_STOP_REQUEST_I),
		.wake_start_i(main_wake),
		.tick_i(settle_tick),
		.target_i(main_target),
		.status_o(main_st),
		.settling_o(main_settling),
		.restart_o(main_restart)
	);
	// ************************************************
	// high speed oscillator
	// ************************************************
	oesc_pkg::oesc_ctrl_t hs_ctrl;
	logic hs_settling;
	assign hs_ctrl.start = HS_OSC_START_TRIGGER_I & ~hs_st.active; // R20
	assign hs_ctrl.stop = HS_OSC_STOP_TRIGGER_I & hs_st.active; // R20
	assign hs_ctrl.stop_mask = HS_OSC_STOP_MASK_I;
	oesc_osc_ctl #(
		.CNT_W(`OESC_CNT_W),
		.RESET_ON(1'b1)
	) u_hs (
		.clk_i(CORE_CLK_I),
		.rst_i(POWER_UP_RESET_I), // R14 R18
		.ctrl_i(hs_ctrl),
		.stop_req_i(STANDBY_STOP_REQUEST_I),
		.wake_start_i(1'b0),
		.tick_i(ls_tick), // R16
		.target_i(`OESC_CNT_W'(`OESC_HS_SETTLE_PERIODS)), // R16
		.status_o(hs_st),
		.settling_o(hs_settling),
		.restart_o()
	);
	// ************************************************
	// registered outputs and constant outputs
	// ************************************************
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			MAIN_OSC_ENABLED_FLAG_O <= 1'b0;
			MAIN_OSC_STABLE_FLAG_O <= 1'b0;
			MAIN_OSC_ACTIVE_FLAG_O <= 1'b0;
			MAIN_OSC_GATE_O <= 1'b0;
			MAIN_OSC_MAX_GAIN_O <= 1'b0;
			MAIN_CLOCK_MONITOR_EN_O <= 1'b0;
		end else begin
			MAIN_OSC_ENABLED_FLAG_O <= main_st.enabled; // R1
			MAIN_OSC_STABLE_FLAG_O <= main_st.stable; // R4
			MAIN_OSC_ACTIVE_FLAG_O <= main_st.active; // R6
			MAIN_OSC_GATE_O <= main_st.stable; // R3 R4
			MAIN_OSC_MAX_GAIN_O <= MAIN_OSC_FAST_SETTLE_I & main_settling
				& main_restart; // R8
			MAIN_CLOCK_MONITOR_EN_O <= main_st.active; // R12
		end
	end
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			HS_OSC_ENABLED_FLAG_O <= 1'b0;
			HS_OSC_STABLE_FLAG_O <= 1'b0;
			HS_OSC_ACTIVE_FLAG_O <= 1'b0;
			HS_OSC_GATE_O <= 1'b0;
			HS_CLOCK_MONITOR_EN_O <= 1'b0;
		end else begin
			HS_OSC_ENABLED_FLAG_O <= hs_st.enabled; // R15
			HS_OSC_STABLE_FLAG_O <= hs_st.stable; // R16
			HS_OSC_ACTIVE_FLAG_O <= hs_st.active; // R16
			HS_OSC_GATE_O <= hs_st.stable && !hs_settling; // R16
			HS_CLOCK_MONITOR_EN_O <= hs_st.active;
		end
	end
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			MONITOR_SAMPLE_TICK_O <= 1'b0;
		end else begin
			MONITOR_SAMPLE_TICK_O <= ls_tick; // R13
		end
	end
	assign LS_OSC_RUN_O = 1'b1; // R13
	assign TRIGGER_READBACK_O = 4'h0; // R21
endmodule : oesc_top

/* File: verilog/oesc_defs.svh */
// constants for the oscillator enable and settle control
// assumes a 125 MHz core clock and internal oscillators modelled as enables
`ifndef OESC_DEFS_SVH
`define OESC_DEFS_SVH
// How it works
// R1 - main start trigger enables main osc, stop trigger disables it
// R2 - main start acts only when inactive, stop only when active
// R3 - after start main settle counter runs, clock gated throughout
// R4 - at selected count main stable flag sets and clock passes
// R5 - settle field picks 2^2 to 2^17 settle clock periods
// R6 - main active flag shows clock present; software waits for it
// R7 - settle clock is hs clock when hs enabled, else ls clock
// R8 - fast settle after wake restart gives max gain until stable
// R9 - unmasked standby request stops main osc; restarts if it ran
// R10 - main osc stopped before standby stays stopped unless wake start
// R11 - wake start signal starts main osc regardless of earlier state
// R12 - main active flag drives main clock monitor enable
// R13 - ls osc always runs, samples both clock monitors
// R14 - hs osc runs after power-up reset; other resets leave it
// R15 - hs start trigger enables hs osc, stop trigger disables it
// R16 - hs output gated until four ls clock periods counted
// R17 - unmasked standby stops hs osc; restarts only if it ran
// R18 - of the resets only power-up reset enables hs osc; system reset spares it
// R19 - main osc disabled after power-up reset release
// R20 - hs start acts only when inactive, stop only when active
// R21 - triggers are single-cycle pulses, never stored, read as zero
`define OESC_CLK_HZ 125000000
`define OESC_HS_HZ 8000000
`define OESC_LS_HZ 240000
`define OESC_HS_DIV (`OESC_CLK_HZ / `OESC_HS_HZ)
`define OESC_LS_DIV (`OESC_CLK_HZ / `OESC_LS_HZ)
`define OESC_SETTLE_W 4
`define OESC_SETTLE_MIN_EXP 2
`define OESC_HS_SETTLE_PERIODS 4
`define OESC_CNT_W 18
`endif

/* File: verilog/oesc_pkg.sv */
// types for the oscillator enable and settle control
// assumes oesc_defs.svh holds the numbers
package oesc_pkg;
	typedef enum logic [1:0] {OSC_OFF, OSC_SETTLE, OSC_RUN, OSC_PARK} oesc_state_t;
	typedef struct packed {
		logic enabled;
		logic stable;
		logic active;
	} oesc_status_t;
	typedef struct packed {
		logic start;
		logic stop;
		logic stop_mask;
	} oesc_ctrl_t;
endpackage : oesc_pkg

/* File: verilog/oesc_osc_ctl.sv */
// one oscillator enable, standby and settle sequencer
// assumes tick_i is a one-cycle settle clock enable
`timescale 1ns/10ps
module oesc_osc_ctl #(
	parameter int CNT_W = 18,
	parameter bit RESET_ON = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire oesc_pkg::oesc_ctrl_t ctrl_i,
	input wire logic stop_req_i,
	input wire logic wake_start_i,
	input wire logic tick_i,
	input wire logic [CNT_W-1:0] target_i,
	output oesc_pkg::oesc_status_t status_o,
	output logic settling_o,
	output logic restart_o
);
	initial begin
		if (CNT_W < 3) $error("oesc_osc_ctl: CNT_W too small");
	end
	// ************************************************
	// state
	// ************************************************
	oesc_pkg::oesc_state_t state_q;
	logic [CNT_W-1:0] cnt_q;
	logic restart_q;
	logic run_req;
	assign run_req = ctrl_i.stop_mask | ~stop_req_i;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= RESET_ON ? oesc_pkg::OSC_SETTLE : oesc_pkg::OSC_OFF;
			restart_q <= 1'b0;
		end else begin
			case (state_q)
				oesc_pkg::OSC_OFF: begin
					if (ctrl_i.start || wake_start_i) begin // R1 R11 R15
						state_q <= oesc_pkg::OSC_SETTLE;
						restart_q <= wake_start_i;
					end
				end
				oesc_pkg::OSC_SETTLE, oesc_pkg::OSC_RUN: begin
					if (ctrl_i.stop) begin // R1 R15
						state_q <= oesc_pkg::OSC_OFF;
					end else if (!run_req) begin // R9 R17
						state_q <= oesc_pkg::OSC_PARK;
					end else if (state_q == oesc_pkg::OSC_SETTLE
						&& tick_i && cnt_q >= target_i) begin // R4 R16
						state_q <= oesc_pkg::OSC_RUN;
						restart_q <= 1'b0;
					end
				end
				oesc_pkg::OSC_PARK: begin
					if (run_req) begin // R9 R17
						state_q <= oesc_pkg::OSC_SETTLE;
						restart_q <= 1'b1;
					end
				end
				default: state_q <= oesc_pkg::OSC_OFF;
			endcase
		end
	end
	// settle countdown seen as up count against target
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		end else if (state_q != oesc_pkg::OSC_SETTLE) begin
			cnt_q <= '0; // R3
		end else if (tick_i && cnt_q < target_i) begin
			cnt_q <= cnt_q + 1'b1; // R3
		end
	end
	// active only when settled into OSC_RUN, not while settling or parked by standby
	assign status_o.enabled = (state_q != oesc_pkg::OSC_OFF); // R1 R15
	assign status_o.stable = (state_q == oesc_pkg::OSC_RUN); // R4 R16
	assign status_o.active = (state_q == oesc_pkg::OSC_RUN); // R6 R12
	assign settling_o = (state_q == oesc_pkg::OSC_SETTLE);
	assign restart_o = restart_q;
endmodule : oesc_osc_ctl

/* File: dv/oesc_assertions.sv */
// checks on the oscillator enable and settle control ports
// assumes binding to oesc_top, one clock domain
`timescale 1ns/10ps
module oesc_assertions (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic POWER_UP_RESET_I,
	input wire logic MAIN_OSC_START_TRIGGER_I,
	input wire logic MAIN_OSC_STOP_TRIGGER_I,
	input wire logic MAIN_OSC_STOP_MASK_I,
	input wire logic HS_OSC_STOP_MASK_I,
	input wire logic STANDBY_STOP_REQUEST_I,
	input wire logic MAIN_OSC_ENABLED_FLAG_O,
	input wire logic MAIN_OSC_STABLE_FLAG_O,
	input wire logic MAIN_OSC_ACTIVE_FLAG_O,
	input wire logic MAIN_OSC_GATE_O,
	input wire logic MAIN_OSC_MAX_GAIN_O,
	input wire logic HS_OSC_ACTIVE_FLAG_O
);
	// ********
	// checks
	// ********
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I || POWER_UP_RESET_I);
	main_start_a: assert property (MAIN_OSC_START_TRIGGER_I &&
		!MAIN_OSC_ENABLED_FLAG_O && !STANDBY_STOP_REQUEST_I
		|-> ##2 MAIN_OSC_ENABLED_FLAG_O) else $error("start lost");
	main_stop_a: assert property (MAIN_OSC_STOP_TRIGGER_I &&
		MAIN_OSC_ACTIVE_FLAG_O && !STANDBY_STOP_REQUEST_I
		|-> ##[1:3] !MAIN_OSC_ENABLED_FLAG_O) else $error("stop lost");
	start_ignored_a: assert property (MAIN_OSC_START_TRIGGER_I &&
		MAIN_OSC_ACTIVE_FLAG_O && !STANDBY_STOP_REQUEST_I
		|=> MAIN_OSC_ACTIVE_FLAG_O[*3]) else $error("start not ignored");
	main_park_a: assert property (STANDBY_STOP_REQUEST_I &&
		!MAIN_OSC_STOP_MASK_I && MAIN_OSC_ACTIVE_FLAG_O
		|-> ##[1:3] !MAIN_OSC_ACTIVE_FLAG_O) else $error("no park");
	mask_keep_a: assert property ($rose(STANDBY_STOP_REQUEST_I) &&
		MAIN_OSC_STOP_MASK_I && MAIN_OSC_ACTIVE_FLAG_O
		|=> MAIN_OSC_ACTIVE_FLAG_O[*4]) else $error("masked osc stopped");
	hs_park_a: assert property ($rose(STANDBY_STOP_REQUEST_I) &&
		!HS_OSC_STOP_MASK_I && HS_OSC_ACTIVE_FLAG_O
		|-> ##[1:3] !HS_OSC_ACTIVE_FLAG_O) else $error("hs no park");
	gate_open_a: assert property (MAIN_OSC_GATE_O |->
		MAIN_OSC_STABLE_FLAG_O && MAIN_OSC_ACTIVE_FLAG_O)
		else $error("gate open early");
	gain_span_a: assert property (MAIN_OSC_MAX_GAIN_O |->
		MAIN_OSC_ENABLED_FLAG_O && !MAIN_OSC_STABLE_FLAG_O)
		else $error("gain when stable");
	cover property ($rose(MAIN_OSC_MAX_GAIN_O));
	cover property ($fell(MAIN_OSC_ACTIVE_FLAG_O));
	cover property ($rose(HS_OSC_ACTIVE_FLAG_O));
endmodule : oesc_assertions

/* File: dv/oesc_stby_model.sv */
// stand-by controller model feeding the oscillator control
// assumes bench levels change on rising clock edges
`timescale 1ns/10ps
module oesc_stby_model (
	input wire logic clk_i,
	input wire logic standby_i,
	input wire logic wake_i,
	output logic stop_req_o,
	output logic wake_start_o
);
	// ********
	// request and wake start
	// ********
	always_ff @(posedge clk_i) begin
		stop_req_o <= standby_i;
		wake_start_o <= wake_i;
	end
endmodule : oesc_stby_model

/* File: dv/oesc_top_tb.sv */
// bench for the oscillator enable and settle control
// assumes the stand-by model drives request and wake start
`timescale 1ns/10ps
module oesc_top_tb;
	localparam int LS = 16;
	localparam int HS = 4;
	logic clk = 1'h0, rst = 1'h1, pur = 1'h1, fast = 1'h0;
	logic m_mk = 1'h0, h_mk = 1'h0, sb = 1'h0, wk = 1'h0;
	logic [3:0] trg = 4'h0, cnt = 4'h0, rb;
	logic stb, wst, men, mst, mac, mgt, mgn, mmon;
	logic hen, hst, hac, hgt, hmon, lsr, tck;
	int bad_count = 0, cmp_count = 0, n;
	always #4 clk = ~clk;
	oesc_stby_model sbm (.clk_i(clk), .standby_i(sb), .wake_i(wk),
		.stop_req_o(stb), .wake_start_o(wst));
	oesc_top #(.LS_DIV(LS), .HS_DIV(HS)) DUT (.CORE_CLK_I(clk),
		.RST_I(rst), .POWER_UP_RESET_I(pur),
		.MAIN_OSC_START_TRIGGER_I(trg[0]), .MAIN_OSC_STOP_TRIGGER_I(trg[1]),
		.MAIN_OSC_STOP_MASK_I(m_mk), .MAIN_OSC_SETTLE_COUNT_I(cnt),
		.MAIN_OSC_FAST_SETTLE_I(fast), .HS_OSC_START_TRIGGER_I(trg[2]),
		.HS_OSC_STOP_TRIGGER_I(trg[3]), .HS_OSC_STOP_MASK_I(h_mk),
		.STANDBY_STOP_REQUEST_I(stb), .WAKE_OSC_START_I(wst),
		.MAIN_OSC_ENABLED_FLAG_O(men), .MAIN_OSC_STABLE_FLAG_O(mst),
		.MAIN_OSC_ACTIVE_FLAG_O(mac), .MAIN_OSC_GATE_O(mgt),
		.MAIN_OSC_MAX_GAIN_O(mgn), .MAIN_CLOCK_MONITOR_EN_O(mmon),
		.HS_OSC_ENABLED_FLAG_O(hen), .HS_OSC_STABLE_FLAG_O(hst),
		.HS_OSC_ACTIVE_FLAG_O(hac), .HS_OSC_GATE_O(hgt),
		.HS_CLOCK_MONITOR_EN_O(hmon), .LS_OSC_RUN_O(lsr),
		.MONITOR_SAMPLE_TICK_O(tck), .TRIGGER_READBACK_O(rb));
	// ********
	// tasks
	// ********
	task automatic chk(string s, logic [3:0] e, logic [3:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic cyc(int k);
		repeat (k) @(posedge clk);
	endtask : cyc
	task automatic pulse(logic [3:0] t);
		@(posedge clk);
		trg <= t;
		@(posedge clk);
		trg <= 4'h0;
	endtask : pulse
	task automatic wt(ref logic f, input logic v, output int c);
		c = 0;
		@(negedge clk);
		while (f !== v && c < 3000) begin
			@(negedge clk);
			c++;
		end
	endtask : wt
	task automatic settle(int t, int p);
		pulse(4'h1);
		cyc(2);
		wt(mac, 1'h1, n);
		chk("settle", 4'h1, n >= t - 1 && n <= t + p);
		chk("stable", 4'hF, {mst, mgt, mmon, mac});
	endtask : settle
	task automatic standby(logic w);
		cyc(1);
		sb <= 1'h1;
		wk <= w;
		cyc(6);
		sb <= 1'h0;
		cyc(4);
		wk <= 1'h0;
		@(negedge clk);
	endtask : standby
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	// ********
	// tests
	// ********
	initial begin
		cyc(10);
		rst <= 1'h0;
		pur <= 1'h0;
		cyc(2 * LS);
		@(negedge clk);
		chk("boot", 4'h2, {men, mgt, lsr, rb[0]});
		chk("readback", 4'h0, rb);
		chk("hs early", 4'h0, hac);
		n = 0;
		repeat (2 * LS) begin
			@(negedge clk);
			n += int'(tck);
		end
		chk("sample tick", 4'h2, 4'(n));
		wt(hac, 1'h1, n);
		chk("hs up", 4'hF, {hen, hst, hgt, hmon});
		for (int k = 0; k < 3; k++) begin
			cyc(1);
			cnt <= 4'(k);
			settle((4 << k) * HS, HS);
			pulse(4'h1);
			cyc(3);
			@(negedge clk);
			chk("start ignored", 4'h1, mac);
			pulse(4'h2);
			wt(men, 1'h0, n);
			chk("stop", 4'h0, {men, mac});
		end
		cyc(1);
		cnt <= 4'h0;
		fast <= 1'h1;
		settle(4 * HS, HS);
		standby(1'h0);
		chk("park", 4'h0, {mac, hac});
		wt(mgn, 1'h1, n);
		chk("gain", 4'h3, {men, mgn});
		wt(mac, 1'h1, n);
		chk("resume", 4'h2, {mac, mgn});
		cyc(1);
		m_mk <= 1'h1;
		standby(1'h0);
		chk("masked", 4'h1, mac);
		cyc(1);
		m_mk <= 1'h0;
		pulse(4'h2);
		standby(1'h0);
		chk("stays off", 4'h0, men);
		standby(1'h1);
		chk("wake start", 4'h1, men);
		wt(mac, 1'h1, n);
		pulse(4'h2);
		wt(hac, 1'h1, n);
		pulse(4'h8);
		wt(hen, 1'h0, n);
		chk("hs stop", 4'h0, {hen, hac, hgt});
		standby(1'h0);
		chk("hs stays off", 4'h0, hen);
		settle(4 * LS, LS);
		cyc(1);
		rst <= 1'h1;
		cyc(3);
		rst <= 1'h0;
		cyc(3);
		@(negedge clk);
		chk("sys reset", 4'h2, {men, hen});
		pulse(4'h4);
		cyc(2);
		@(negedge clk);
		chk("hs start", 4'h2, {hen, hgt});
		give_verdict();
	end
	initial begin
		cyc(20000);
		bad_count++;
		give_verdict();
	end
endmodule : oesc_top_tb
bind oesc_top oesc_assertions chk_i (.*);
